// file: src/enhanced_serial_port.sv
// Full-duplex serial port with shift-register and three asynchronous modes.
// Assumes Timer 1 overflow arrives as a one-cycle pulse on this clock and the
// receive pin is asynchronous to it.
`timescale 1ns/1ps
module enhanced_serial_port
(
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire serial_port_pkg::bus_req_type bus,
    output logic [7:0]                       rdata,
    input  wire logic                        timer1_overflow,
    input  wire logic                        rxd_in,
    output logic                             rxd_out,
    output logic                             rxd_oe_b,
    output logic                             txd,
    output logic                             tx_done_flag,
    output logic                             rx_done_flag
);
    import serial_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic               mode_sel_hi;
    logic               mode_sel_lo;
    logic               multiproc_enable;
    logic               rx_enable;
    logic               tx_ninth_bit;
    logic               rx_ninth_bit;
    logic               frame_err_flag;
    logic               baud_double;
    logic               bit7_select;
    logic [1:0]         mode;
    logic               wr_ctrl;
    logic               wr_buf;
    logic               wr_power;
    logic [2:0]         mc;
    logic               rxd_meta;
    logic               rxd_s2;
    logic               rxd_s3;
    logic               rxd_level;
    logic               rxd_level_d;
    logic               rxd_fall;
    logic               half;
    logic               rate_src;
    logic               tick16;
    tx_state_type       tx_state;
    logic [10:0]        tx_shift;
    logic [3:0]         tx_left;
    logic [3:0]         tx_phase;
    rx_state_type       rx_state;
    logic [10:0]        rx_shift;
    logic [3:0]         rx_count;
    logic [3:0]         rx_phase;
    logic [3:0]         rx_nbits;
    logic [7:0]         rx_buffer;
    logic [7:0]         rx_data;
    logic               rx_stop;
    logic               rx_ninth;
    logic               rx_load;
    logic               tx_done_set;
    logic               fe_set;
    logic               clk_high;
    logic               shift_clk_on;

    assign mode     = {mode_sel_hi, mode_sel_lo};
    assign wr_ctrl  = bus.wr && (bus.addr == CTRL_ADDR);
    assign wr_buf   = bus.wr && (bus.addr == BUFFER_ADDR);
    assign wr_power = bus.wr && (bus.addr == POWER_ADDR);
    assign rxd_fall = rxd_level_d && !rxd_level;
    assign rx_nbits = mode[1] ? FRAME9_BITS : FRAME8_BITS;

    ////////////////////////////////////////////////////////////////////////////
    // Machine cycle of six clocks paces mode 0.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            mc <= MC_FIRST;
        else if (mc == MC_LAST)
            mc <= MC_FIRST;
        else
            mc <= mc + 3'h1;
    end

    // The first stage is read only by the second; a level is taken once two
    // later stages agree, which filters single-cycle glitches.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxd_meta    <= 1'b1;
            rxd_s2      <= 1'b1;
            rxd_s3      <= 1'b1;
            rxd_level   <= 1'b1;
            rxd_level_d <= 1'b1;
        end
        else
        begin
            rxd_meta    <= rxd_in;
            rxd_s2      <= rxd_meta;
            rxd_s3      <= rxd_s2;
            rxd_level_d <= rxd_level;
            if (rxd_s2 == rxd_s3)
                rxd_level <= rxd_s3;
        end
    end

    // Sixteen-times bit clock: mode 2 from the CPU clock, modes 1 and 3 from
    // Timer 1; the halving stage is skipped when the rate is doubled.
    assign rate_src = (mode == MODE_FIX9) ? 1'b1 : timer1_overflow;
    assign tick16   = rate_src && (baud_double || half);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            half <= 1'b0;
        else if (rate_src)
            half <= !half;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter; a new buffer write always restarts it.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_state <= TX_IDLE;
            tx_shift <= '1;
            tx_left  <= '0;
            tx_phase <= '0;
        end
        else if (wr_buf)
        begin
            tx_phase <= '0;
            if (mode == MODE_SHIFT)
            begin
                tx_state <= TX_WAIT0;
                tx_shift <= {3'h7, bus.wdata};
                tx_left  <= MODE0_BITS;
            end
            else
            begin
                tx_state <= TX_FRAME;
                tx_shift <= {1'b1, mode[1] ? tx_ninth_bit : 1'b1, bus.wdata, 1'b0};
                tx_left  <= rx_nbits;
            end
        end
        else
        begin
            unique case (tx_state)
                TX_IDLE:
                    tx_state <= TX_IDLE;
                TX_WAIT0:
                    if (mc == MC_SHIFT)
                        tx_state <= TX_SEND0;
                TX_SEND0:
                    if (mc == MC_SHIFT)
                    begin
                        tx_shift <= {1'b1, tx_shift[10:1]};
                        tx_left  <= tx_left - 4'h1;
                        if (tx_left == LAST_LEFT)
                            tx_state <= TX_LAST0;
                    end
                TX_LAST0:
                    if (mc == MC_FIRST)
                        tx_state <= TX_IDLE;
                TX_FRAME:
                    if (tick16)
                    begin
                        tx_phase <= tx_phase + 4'h1;
                        if (tx_phase == PHASE_LAST)
                        begin
                            tx_shift <= {1'b1, tx_shift[10:1]};
                            tx_left  <= tx_left - 4'h1;
                            if (tx_left == LAST_LEFT)
                                tx_state <= TX_IDLE;
                        end
                    end
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    assign tx_done_set = !wr_buf &&
        (((tx_state == TX_LAST0) && (mc == MC_FIRST)) ||
         ((tx_state == TX_FRAME) && tick16 && (tx_phase == PHASE_LAST) &&
          (tx_left == STOP_LEFT)));

    ////////////////////////////////////////////////////////////////////////////
    // Receiver with its own shift register, so in modes 1 to 3 it can run while
    // the buffer still holds an unread byte.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_state <= RX_IDLE;
            rx_shift <= '1;
            rx_count <= '0;
            rx_phase <= '0;
        end
        else
        begin
            unique case (rx_state)
                RX_IDLE:
                    if (rx_enable)
                    begin
                        if (mode == MODE_SHIFT)
                        begin
                            if (!rx_done_flag)
                            begin
                                rx_state <= RX_SHIFT0;
                                rx_count <= MODE0_BITS;
                            end
                        end
                        else if (rxd_fall)
                        begin
                            rx_state <= RX_FRAME;
                            rx_phase <= '0;
                            rx_count <= rx_nbits;
                        end
                    end
                RX_SHIFT0:
                    if (mc == MC_SAMPLE)
                    begin
                        rx_shift <= {rxd_level, rx_shift[10:1]};
                        rx_count <= rx_count - 4'h1;
                        if (rx_count == LAST_LEFT)
                            rx_state <= RX_DONE;
                    end
                RX_FRAME:
                    if (tick16)
                    begin
                        rx_phase <= rx_phase + 4'h1;
                        if (rx_phase == PHASE_MID)
                        begin
                            // A start bit gone high by mid-bit was noise.
                            if ((rx_count == rx_nbits) && rxd_level)
                                rx_state <= RX_IDLE;
                            else
                            begin
                                rx_shift <= {rxd_level, rx_shift[10:1]};
                                rx_count <= rx_count - 4'h1;
                                if (rx_count == LAST_LEFT)
                                    rx_state <= RX_DONE;
                            end
                        end
                    end
                RX_DONE:
                    rx_state <= RX_IDLE;
            endcase
        end
    end

    // Field positions differ by frame length after the last shift.
    always_comb
    begin
        if (mode == MODE_SHIFT)
            rx_data = rx_shift[10:3];
        else if (mode[1])
            rx_data = rx_shift[8:1];
        else
            rx_data = rx_shift[9:2];
        rx_stop  = rx_shift[10];
        rx_ninth = mode[1] ? rx_shift[9] : rx_stop;
    end

    // Mode 0 ignores the multiprocessor bit, which software keeps clear there.
    assign rx_load = (rx_state == RX_DONE) &&
        ((mode == MODE_SHIFT) || !multiproc_enable || rx_ninth);
    assign fe_set  = (rx_state == RX_DONE) && (mode != MODE_SHIFT) && !rx_stop;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rx_buffer <= '0;
        else if (rx_load)
            rx_buffer <= rx_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control bits; a hardware set wins over a software write in the same cycle.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_sel_hi      <= CTRL_RESET[BIT_MODE_HI];
            mode_sel_lo      <= CTRL_RESET[BIT_MODE_LO];
            multiproc_enable <= CTRL_RESET[BIT_MULTIPROC];
            rx_enable        <= CTRL_RESET[BIT_RX_ENABLE];
            tx_ninth_bit     <= CTRL_RESET[BIT_TX_NINTH];
        end
        else if (wr_ctrl)
        begin
            if (!bit7_select)
                mode_sel_hi <= bus.wdata[BIT_MODE_HI];
            mode_sel_lo      <= bus.wdata[BIT_MODE_LO];
            multiproc_enable <= bus.wdata[BIT_MULTIPROC];
            rx_enable        <= bus.wdata[BIT_RX_ENABLE];
            tx_ninth_bit     <= bus.wdata[BIT_TX_NINTH];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_done_flag   <= CTRL_RESET[BIT_TX_DONE];
            rx_done_flag   <= CTRL_RESET[BIT_RX_DONE];
            rx_ninth_bit   <= CTRL_RESET[BIT_RX_NINTH];
            frame_err_flag <= 1'b0;
        end
        else
        begin
            if (tx_done_set)
                tx_done_flag <= 1'b1;
            else if (wr_ctrl)
                tx_done_flag <= bus.wdata[BIT_TX_DONE];
            if (rx_load)
                rx_done_flag <= 1'b1;
            else if (wr_ctrl)
                rx_done_flag <= bus.wdata[BIT_RX_DONE];
            if (rx_load && (mode != MODE_SHIFT))
                rx_ninth_bit <= rx_ninth;
            else if (wr_ctrl)
                rx_ninth_bit <= bus.wdata[BIT_RX_NINTH];
            if (fe_set)
                frame_err_flag <= 1'b1;
            else if (wr_ctrl && bit7_select)
                frame_err_flag <= bus.wdata[BIT_MODE_HI];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            baud_double <= POWER_RESET[BIT_DOUBLE];
            bit7_select <= POWER_RESET[BIT_SELECT];
        end
        else if (wr_power)
        begin
            baud_double <= bus.wdata[BIT_DOUBLE];
            bit7_select <= bus.wdata[BIT_SELECT];
        end
    end

    // Read data stand only in the cycle after the strobe; otherwise zero.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= '0;
        else if (bus.rd && (bus.addr == CTRL_ADDR))
            rdata <= {bit7_select ? frame_err_flag : mode_sel_hi, mode_sel_lo,
                      multiproc_enable, rx_enable, tx_ninth_bit, rx_ninth_bit,
                      tx_done_flag, rx_done_flag};
        else if (bus.rd && (bus.addr == BUFFER_ADDR))
            rdata <= rx_buffer;
        else if (bus.rd && (bus.addr == POWER_ADDR))
            rdata <= {baud_double, bit7_select, 6'h00};
        else
            rdata <= '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins: in mode 0 the transmit pin carries the shift clock and the receive
    // pin carries data both ways; otherwise the transmit pin carries frames.
    assign clk_high     = (mc < MC_LOW_FROM) || (mc > MC_LOW_TO);
    assign shift_clk_on = (tx_state == TX_SEND0) || (tx_state == TX_LAST0) ||
                          (rx_state == RX_SHIFT0);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txd      <= 1'b1;
            rxd_out  <= 1'b1;
            rxd_oe_b <= 1'b1;
        end
        else
        begin
            if (mode == MODE_SHIFT)
                txd <= shift_clk_on ? clk_high : 1'b1;
            else
                txd <= (tx_state == TX_FRAME) ? tx_shift[0] : 1'b1;
            rxd_out  <= tx_shift[0];
            rxd_oe_b <= !((mode == MODE_SHIFT) && (tx_state == TX_SEND0));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_send0_begins;
        (tx_state == TX_WAIT0) ##1 (tx_state == TX_SEND0);
    endsequence

    sequence s_frame_done;
        (rx_state == RX_DONE) && (mode != MODE_SHIFT);
    endsequence

    a_write_starts_tx: assert property (wr_buf |=> (tx_state != TX_IDLE))
        else $error("buffer write did not start transmission");
    a_read_rx_buffer: assert property ((bus.rd && (bus.addr == BUFFER_ADDR)) |=>
        (rdata == $past(rx_buffer)))
        else $error("buffer read did not return receive register");
    a_bit7_view: assert property ((bus.rd && (bus.addr == CTRL_ADDR)) |=>
        (rdata[7] == $past(bit7_select ? frame_err_flag : mode_sel_hi)))
        else $error("control bit 7 shows the wrong field");
    a_fe_sticky: assert property ((frame_err_flag && !(wr_ctrl && bit7_select)) |=>
        frame_err_flag)
        else $error("framing error cleared without software");
    a_ti_at_stop: assert property (($rose(tx_done_flag) && (mode != MODE_SHIFT)) |->
        ((tx_state == TX_FRAME) && tx_shift[0]))
        else $error("transmit done not at stop bit");
    a_mp_ninth: assert property ((s_frame_done and
        (mode[1] && multiproc_enable && !rx_shift[9])) |=> !$rose(rx_done_flag))
        else $error("address filter let a data frame through");
    a_mode1_stop: assert property ((s_frame_done and
        ((mode == MODE_UART8) && multiproc_enable && !rx_shift[10])) |=>
        !$rose(rx_done_flag))
        else $error("mode 1 frame without stop accepted");
    a_send0_length: assert property (s_send0_begins |-> (tx_state == TX_SEND0)[*6])
        else $error("mode 0 bit shorter than a machine cycle");
    a_shift_clk_low: assert property (((tx_state == TX_SEND0) && (mc == MC_LOW_FROM) &&
        (mode == MODE_SHIFT) && !wr_buf && !wr_ctrl) |=> !txd ##1 !txd)
        else $error("mode 0 shift clock not low in its phase");
    a_buffer_load: assert property (rx_load |=> (rx_buffer == $past(rx_data)))
        else $error("received byte not loaded into buffer");
    a_last0_done: assert property (((tx_state == TX_LAST0) && (mc == MC_FIRST) && !wr_buf) |=>
        (tx_done_flag && (tx_state == TX_IDLE)))
        else $error("mode 0 transmission end not flagged");

endmodule : enhanced_serial_port

// file: src/serial_port_pkg.sv
// Constants, register map and shared types of the serial port.
// Assumes a single 20 MHz clock and a CPU that drives the plain register port.
//
// How it works
// - Transmit and receive paths run independently.
// - In modes 1 to 3 a completed byte overwrites an unread buffer.
// - Buffer write loads transmitter, read gives receiver.
// - Mode 0 shifts eight bits on receive pin.
// - Mode 1: start, eight data, stop.
// - Modes 1 and 3 use Timer 1 overflow.
// - Modes 2 and 3 send ninth bit.
// - Mode 2 stores ninth bit; stop only sets framing error.
// - Mode 2 rate is clock/32 or clock/16.
// - Mode 3 frames exactly like mode 2.
// - Only a buffer write starts transmission.
// - Reception start conditions per mode.
// - Control bit 7 shows error or mode.
// - Framing error is sticky until cleared.
// - Two mode bits select four modes.
// - Multiprocessor mode drops frames with ninth zero.
// - Done flags are the interrupt sources.
// - Mode 1 multiprocessor needs valid stop.
// - Rate-double bit resets to zero.
// - Mode 0 transmission ends in tenth machine cycle.
package serial_port_pkg;

    localparam logic [7:0] CTRL_ADDR   = 8'h98;
    localparam logic [7:0] BUFFER_ADDR = 8'h99;
    localparam logic [7:0] POWER_ADDR  = 8'h87;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] POWER_RESET = 8'h00;

    localparam int BIT_MODE_HI   = 7;
    localparam int BIT_MODE_LO   = 6;
    localparam int BIT_MULTIPROC = 5;
    localparam int BIT_RX_ENABLE = 4;
    localparam int BIT_TX_NINTH  = 3;
    localparam int BIT_RX_NINTH  = 2;
    localparam int BIT_TX_DONE   = 1;
    localparam int BIT_RX_DONE   = 0;
    localparam int BIT_DOUBLE    = 7;
    localparam int BIT_SELECT    = 6;

    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [1:0] MODE_FIX9  = 2'h2;
    localparam logic [1:0] MODE_VAR9  = 2'h3;

    localparam logic [2:0] MC_FIRST    = 3'h0;
    localparam logic [2:0] MC_LOW_FROM = 3'h2;
    localparam logic [2:0] MC_LOW_TO   = 3'h4;
    localparam logic [2:0] MC_SAMPLE   = 3'h4;
    localparam logic [2:0] MC_SHIFT    = 3'h5;
    localparam logic [2:0] MC_LAST     = 3'h5;

    localparam logic [3:0] PHASE_MID   = 4'h7;
    localparam logic [3:0] PHASE_LAST  = 4'hF;
    localparam logic [3:0] MODE0_BITS  = 4'h8;
    localparam logic [3:0] FRAME8_BITS = 4'hA;
    localparam logic [3:0] FRAME9_BITS = 4'hB;
    localparam logic [3:0] STOP_LEFT   = 4'h2;
    localparam logic [3:0] LAST_LEFT   = 4'h1;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    typedef enum logic [2:0] {TX_IDLE, TX_WAIT0, TX_SEND0, TX_LAST0, TX_FRAME} tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT0, RX_FRAME, RX_DONE} rx_state_type;

endpackage : serial_port_pkg

// file: verif/remote_serial.sv
// Model of the remote serial device that drives the receive pin.
// Assumes the testbench calls send_frame from its own sequence.
`timescale 1ns/1ps
module remote_serial
(
    input  wire logic clk,
    output logic      line
);
    initial line = 1'b1;
    ////////////////////////////////////////////////////////////////////////////
    // The line idles high; a longer period models a slow sender.
    task automatic send_frame(input logic [7:0] d, input logic ninth, input logic stop,
                              input int period);
        logic [10:0] bits;
        begin
            bits = {stop, ninth, d, 1'b0};
            for (int i = 0; i < 11; i++)
            begin
                @(posedge clk);
                line <= bits[i];
                repeat (period - 1) @(posedge clk);
            end
            @(posedge clk);
            line <= 1'b1;
            repeat (period - 1) @(posedge clk);
        end
    endtask : send_frame
endmodule : remote_serial

// file: verif/test_enhanced_serial_port.sv
// Self-checking bench for the serial port in its fixed-rate nine-bit mode and its shift-register mode.
// Assumes the remote model drives the receive pin whenever the port releases it.
`timescale 1ns/1ps
module test_enhanced_serial_port;
    import serial_port_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        timer1_overflow;
    logic        rxd_out;
    logic        rxd_oe_b;
    logic        txd;
    logic        tx_done_flag;
    logic        rx_done_flag;
    logic [7:0]  rdata;
    wire  logic  line;
    bus_req_type bus;
    int          error_cnt = 0;
    int          checks_done = 0;
    // The pin carries the port's level only while it drives it.
    wire  logic  rxd_in = rxd_oe_b ? line : rxd_out;

    enhanced_serial_port enhanced_serial_port_inst (.clk(clk), .rst_b(rst_b), .bus(bus),
        .rdata(rdata), .timer1_overflow(timer1_overflow), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe_b(rxd_oe_b), .txd(txd), .tx_done_flag(tx_done_flag),
        .rx_done_flag(rx_done_flag));
    remote_serial remote_serial_inst (.clk(clk), .line(line));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        check(rdata, exp);
    endtask : rd_chk
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        rd_chk(CTRL_ADDR, CTRL_RESET);
        rd_chk(POWER_ADDR, 8'h00);
        rd_chk(8'h55, 8'h00);
    endtask : test_reset

    // Samples every bit in its middle, so a rate off by two fails at once.
    task automatic test_tx(input logic [7:0] pwr, input logic [7:0] ctl, input logic [7:0] d,
                           input int period);
        logic [10:0] exp;
        begin
            exp = {1'b1, ctl[BIT_TX_NINTH], d, 1'b0};
            wr(POWER_ADDR, pwr);
            wr(CTRL_ADDR, ctl);
            wr(BUFFER_ADDR, d);
            repeat (2 + period / 2) @(posedge clk);
            for (int i = 0; i < 11; i++)
            begin
                #1;
                check({7'h00, txd}, {7'h00, exp[i]});
                check({7'h00, tx_done_flag}, {7'h00, logic'(i == 10)});
                repeat (period) @(posedge clk);
            end
            wr(CTRL_ADDR, ctl);
            rd_chk(CTRL_ADDR, ctl);
        end
    endtask : test_tx

    task automatic test_rx;
        wr(POWER_ADDR, 8'h80);
        wr(CTRL_ADDR, 8'hB0);
        remote_serial_inst.send_frame(8'h11, 1'b0, 1'b1, 16);
        #1;
        check({7'h00, rx_done_flag}, 8'h00);
        remote_serial_inst.send_frame(8'h5A, 1'b1, 1'b1, 16);
        #1;
        check({7'h00, rx_done_flag}, 8'h01);
        rd_chk(BUFFER_ADDR, 8'h5A);
        rd_chk(CTRL_ADDR, 8'hB5);
        wr(CTRL_ADDR, 8'h90);
        remote_serial_inst.send_frame(8'hC3, 1'b0, 1'b0, 16);
        remote_serial_inst.send_frame(8'h3C, 1'b1, 1'b1, 16);
        rd_chk(BUFFER_ADDR, 8'h3C);
        wr(POWER_ADDR, 8'hC0);
        rd_chk(CTRL_ADDR, 8'h95);
    endtask : test_rx

    // Mode 0 send: each low phase of the shift clock must carry the next data bit.
    task automatic test_shift0(input logic [7:0] d);
        begin
            wr(POWER_ADDR, 8'h00);
            wr(CTRL_ADDR, 8'h00);
            wr(BUFFER_ADDR, d);
            for (int i = 0; i < 8; i++)
            begin
                @(negedge txd);
                #1;
                check({7'h00, rxd_out}, {7'h00, d[i]});
                check({7'h00, rxd_oe_b}, 8'h00);
            end
            repeat (12) @(posedge clk);
            #1;
            check({7'h00, tx_done_flag}, 8'h01);
            check({7'h00, rxd_oe_b}, 8'h01);
        end
    endtask : test_shift0
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // The whole run takes about fifteen hundred cycles.
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial
    begin
        rst_b = 1'b0;
        bus = '0;
        timer1_overflow = 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        test_reset();
        test_tx(8'h00, 8'h80, 8'h3C, 32);
        test_tx(8'h80, 8'h88, 8'hA5, 16);
        test_rx();
        test_shift0(8'hB4);
        end_sim();
    end
endmodule : test_enhanced_serial_port
